// ### verilog/swtc_pkg.sv
// Package of constants and types for the sweep trigger control block.
package swtc_pkg;

  // ------------------------------------------------------------
  // Clock and time
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned S_PER_HOUR = 3600;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_PER_HOUR = S_PER_HOUR * MS_PER_S;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CMD = 4'h1;
  localparam logic [3:0] OFF_DWELL = 4'h2;
  localparam logic [3:0] OFF_POINTS = 4'h3;
  localparam logic [3:0] OFF_SAVER = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h5;
  localparam logic [3:0] OFF_POINT_NOW = 4'h6;

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int CTRL_CONT = 0;
  localparam int CTRL_SLOPE_NEG = 1;
  localparam int CTRL_OUT_NEG = 2;
  localparam int CTRL_SRC_LO = 3;
  localparam int CTRL_FREQ_SWP = 5;
  localparam int CTRL_POW_SWP = 6;
  localparam int CTRL_SWEPT_SINE = 7;

  // ------------------------------------------------------------
  // Command bits, one-shot on write
  // ------------------------------------------------------------
  localparam int CMD_ABORT = 0;
  localparam int CMD_INIT = 1;
  localparam int CMD_FORCE = 2;
  localparam int CMD_BUS_TRIG = 3;
  localparam int CMD_PRESET = 4;
  localparam int CMD_PERS_PRESET = 5;

  // ------------------------------------------------------------
  // Screen saver fields
  // ------------------------------------------------------------
  localparam int SAV_DELAY_LO = 0;
  localparam int SAV_MODE = 4;
  localparam int SAV_ON = 5;

  // ------------------------------------------------------------
  // Reset and factory values, and write limits
  // ------------------------------------------------------------
  localparam logic [15:0] DWELL_RST = 16'h0002;
  localparam logic [15:0] DWELL_MIN = 16'h0001;
  localparam logic [15:0] DWELL_MAX = 16'hea60;
  localparam logic [8:0] POINTS_RST = 9'h002;
  localparam logic [8:0] POINTS_MIN = 9'h002;
  localparam logic [8:0] POINTS_MAX = 9'h191;
  localparam logic [3:0] SAV_DELAY_FACT = 4'h1;
  localparam logic [3:0] SAV_DELAY_MIN = 4'h1;
  localparam logic [3:0] SAV_DELAY_MAX = 4'hc;
  localparam logic SAV_MODE_FACT = 1'b0;
  localparam logic SAV_ON_FACT = 1'b0;

  typedef enum logic [1:0] {
    SRC_BUS,
    SRC_IMM,
    SRC_EXT,
    SRC_KEY
  } swtc_src_e;

  localparam swtc_src_e SRC_RST = SRC_IMM;

endpackage

// ### verilog/swtc_ms_tick.sv
// Millisecond enable pulse divider.
`timescale 1ns/1ps

module swtc_ms_tick #(
  parameter int unsigned DIV = swtc_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);

  if (DIV < 1) begin
    $error("Divider must be at least one.");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } swtc_tick_s;

  swtc_tick_s st_r;
  swtc_tick_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= 32'(DIV - 1)) begin
      st_nxt.cnt = 32'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

// ### verilog/swtc_top.sv
// Sweep arming, trigger control and screen saver settings.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module swtc_top #(
  parameter int unsigned CYC_MS = swtc_pkg::CYC_PER_MS,
  parameter int unsigned MS_HOUR = swtc_pkg::MS_PER_HOUR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic trig_in,
  input wire logic trig_key,
  input wire logic panel_activity,
  input wire logic point_settled,
  output logic trig_out,
  output logic display_light_off,
  output logic display_text_off,
  output logic bit_error_measurement_on,
  input wire logic bit_error_measurement_start,
  output logic sweep_busy,
  output logic pending_op,
  output logic [8:0] point_index
);

  if (CYC_MS < 1 || MS_HOUR < 1) begin
    $error("Divider counts must be at least one.");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SW_IDLE,
    SW_SETTLE,
    SW_WAIT,
    SW_DWELL,
    SW_RESET
  } swtc_sw_e;

  typedef struct packed {
    swtc_sw_e sw;
    logic cont;
    logic slope_neg;
    logic out_neg;
    swtc_pkg::swtc_src_e src;
    logic freq_swp;
    logic pow_swp;
    logic swept_sine;
    logic [15:0] dwell;
    logic [8:0] points;
    logic [3:0] sav_delay;
    logic sav_mode;
    logic sav_on;
    logic [8:0] pt;
    logic [15:0] dwell_cnt;
    logic [31:0] idle_ms;
    logic [3:0] idle_hr;
    logic blank;
    logic ber_on;
    logic pending;
    logic rearm;
    logic pulse;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic [15:0] rdata;
  } swtc_st_s;

  swtc_st_s st_r;
  swtc_st_s st_nxt;
  logic ms_tick;

  swtc_ms_tick #(
    .DIV(CYC_MS)
  ) u_ms (
    .clk(clk),
    .rst(rst),
    .tick(ms_tick)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic wr_ctrl;
  logic wr_cmd;
  logic ext_edge;
  logic fire;
  logic last_pt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    wr_ctrl = reg_wr && hit(reg_addr, swtc_pkg::OFF_CTRL);
    wr_cmd = reg_wr && hit(reg_addr, swtc_pkg::OFF_CMD);
    st_nxt.trig_s1 = trig_in;
    st_nxt.trig_s2 = st_r.trig_s1;
    st_nxt.trig_s3 = st_r.trig_s2;
    ext_edge = st_r.slope_neg ? (st_r.trig_s3 && !st_r.trig_s2)
                              : (!st_r.trig_s3 && st_r.trig_s2);
    case (st_r.src)
      swtc_pkg::SRC_BUS: fire = wr_cmd && reg_wdata[swtc_pkg::CMD_BUS_TRIG];
      swtc_pkg::SRC_IMM: fire = 1'b1;
      swtc_pkg::SRC_EXT: fire = ext_edge;
      default: fire = trig_key;
    endcase
    if (wr_cmd && reg_wdata[swtc_pkg::CMD_FORCE]) begin
      fire = 1'b1;
    end
    last_pt = (st_r.pt >= st_r.points - 9'h001);

    if (wr_ctrl) begin
      st_nxt.cont = reg_wdata[swtc_pkg::CTRL_CONT];
      st_nxt.slope_neg = reg_wdata[swtc_pkg::CTRL_SLOPE_NEG];
      st_nxt.out_neg = reg_wdata[swtc_pkg::CTRL_OUT_NEG];
      st_nxt.src = swtc_pkg::swtc_src_e'(
        reg_wdata[swtc_pkg::CTRL_SRC_LO +: 2]);
      st_nxt.freq_swp = reg_wdata[swtc_pkg::CTRL_FREQ_SWP];
      st_nxt.pow_swp = reg_wdata[swtc_pkg::CTRL_POW_SWP];
      st_nxt.swept_sine = reg_wdata[swtc_pkg::CTRL_SWEPT_SINE];
    end
    if (reg_wr && hit(reg_addr, swtc_pkg::OFF_DWELL) &&
        reg_wdata >= swtc_pkg::DWELL_MIN &&
        reg_wdata <= swtc_pkg::DWELL_MAX) begin
      st_nxt.dwell = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, swtc_pkg::OFF_POINTS) &&
        reg_wdata[8:0] >= swtc_pkg::POINTS_MIN &&
        reg_wdata[8:0] <= swtc_pkg::POINTS_MAX && reg_wdata[15:9] == 7'h0) begin
      st_nxt.points = reg_wdata[8:0];
    end
    if (reg_wr && hit(reg_addr, swtc_pkg::OFF_SAVER)) begin
      if (reg_wdata[swtc_pkg::SAV_DELAY_LO +: 4] >= swtc_pkg::SAV_DELAY_MIN &&
          reg_wdata[swtc_pkg::SAV_DELAY_LO +: 4] <= swtc_pkg::SAV_DELAY_MAX) begin
        st_nxt.sav_delay = reg_wdata[swtc_pkg::SAV_DELAY_LO +: 4];
      end
      st_nxt.sav_mode = reg_wdata[swtc_pkg::SAV_MODE];
      st_nxt.sav_on = reg_wdata[swtc_pkg::SAV_ON];
    end
    if (bit_error_measurement_start) begin
      st_nxt.ber_on = 1'b1;
    end

    // Sweep sequencer.
    case (st_r.sw)
      SW_IDLE: begin
        if (wr_cmd && reg_wdata[swtc_pkg::CMD_INIT] &&
            (st_r.freq_swp || st_r.pow_swp)) begin
          st_nxt.sw = SW_SETTLE;
          st_nxt.pt = 9'h0;
          st_nxt.pending = 1'b1;
          st_nxt.pulse = st_r.swept_sine;
        end
      end
      SW_SETTLE: begin
        if (point_settled) begin
          st_nxt.sw = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (fire) begin
          st_nxt.sw = (st_r.src == swtc_pkg::SRC_IMM) ? SW_DWELL : SW_SETTLE;
          st_nxt.dwell_cnt = 16'h0;
          if (st_r.src != swtc_pkg::SRC_IMM) begin
            if (last_pt) begin
              st_nxt.sw = SW_RESET;
              st_nxt.rearm = st_r.cont;
            end else begin
              st_nxt.pt = st_r.pt + 9'h001;
            end
          end
        end
      end
      SW_DWELL: begin
        if (ms_tick) begin
          st_nxt.dwell_cnt = st_r.dwell_cnt + 16'h0001;
        end
        if (ms_tick && st_r.dwell_cnt + 16'h0001 >= st_r.dwell) begin
          if (last_pt) begin
            st_nxt.sw = SW_RESET;
            st_nxt.rearm = st_r.cont;
          end else begin
            st_nxt.sw = SW_SETTLE;
            st_nxt.pt = st_r.pt + 9'h001;
          end
        end
      end
      default: begin
        st_nxt.pt = 9'h0;
        if (st_r.rearm && (st_r.freq_swp || st_r.pow_swp)) begin
          st_nxt.sw = SW_SETTLE;
          st_nxt.pulse = st_r.swept_sine;
        end else begin
          st_nxt.sw = SW_IDLE;
          st_nxt.pending = 1'b0;
        end
        st_nxt.rearm = 1'b0;
      end
    endcase

    if (wr_cmd && reg_wdata[swtc_pkg::CMD_ABORT]) begin
      st_nxt.ber_on = 1'b0;
      if (st_r.sw != SW_IDLE) begin
        st_nxt.sw = SW_RESET;
        st_nxt.rearm = st_r.cont;
      end
    end

    if (panel_activity || !st_r.sav_on) begin
      st_nxt.idle_ms = 32'h0;
      st_nxt.idle_hr = 4'h0;
      st_nxt.blank = 1'b0;
    end else if (ms_tick && !st_r.blank) begin
      if (st_r.idle_ms >= 32'(MS_HOUR - 1)) begin
        st_nxt.idle_ms = 32'h0;
        st_nxt.idle_hr = st_r.idle_hr + 4'h1;
        if (st_r.idle_hr + 4'h1 >= st_r.sav_delay) begin
          st_nxt.blank = 1'b1;
        end
      end else begin
        st_nxt.idle_ms = st_r.idle_ms + 32'h1;
      end
    end

    if (wr_cmd && reg_wdata[swtc_pkg::CMD_PRESET]) begin
      st_nxt.cont = 1'b0;
      st_nxt.slope_neg = 1'b0;
      st_nxt.out_neg = 1'b0;
      st_nxt.src = swtc_pkg::SRC_RST;
      st_nxt.dwell = swtc_pkg::DWELL_RST;
      st_nxt.points = swtc_pkg::POINTS_RST;
      st_nxt.freq_swp = 1'b0;
      st_nxt.pow_swp = 1'b0;
      st_nxt.swept_sine = 1'b0;
      if (st_r.sw != SW_IDLE) begin
        st_nxt.sw = SW_RESET;
        st_nxt.rearm = 1'b0;
      end
    end
    // persistent values only by own preset
    if (wr_cmd && reg_wdata[swtc_pkg::CMD_PERS_PRESET]) begin
      st_nxt.sav_delay = swtc_pkg::SAV_DELAY_FACT;
      st_nxt.sav_mode = swtc_pkg::SAV_MODE_FACT;
      st_nxt.sav_on = swtc_pkg::SAV_ON_FACT;
    end

    // Read data, one cycle after the strobe.
    st_nxt.rdata = 16'h0;
    if (reg_rd) begin
      if (hit(reg_addr, swtc_pkg::OFF_CTRL)) begin
        st_nxt.rdata = {8'h0, st_r.swept_sine, st_r.pow_swp, st_r.freq_swp,
                        st_r.src, st_r.out_neg, st_r.slope_neg, st_r.cont};
      end else if (hit(reg_addr, swtc_pkg::OFF_DWELL)) begin
        st_nxt.rdata = st_r.dwell;
      end else if (hit(reg_addr, swtc_pkg::OFF_POINTS)) begin
        st_nxt.rdata = {7'h0, st_r.points};
      end else if (hit(reg_addr, swtc_pkg::OFF_SAVER)) begin
        st_nxt.rdata = {10'h0, st_r.sav_on, st_r.sav_mode, st_r.sav_delay};
      end else if (hit(reg_addr, swtc_pkg::OFF_STATUS)) begin
        st_nxt.rdata = {9'h0, st_r.blank, st_r.ber_on, st_r.pending,
                        1'b0, st_r.sw};
      end else if (hit(reg_addr, swtc_pkg::OFF_POINT_NOW)) begin
        st_nxt.rdata = {7'h0, st_r.pt};
      end else begin
        st_nxt.rdata = 16'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{
        sw: SW_IDLE,
        src: swtc_pkg::SRC_RST,
        dwell: swtc_pkg::DWELL_RST,
        points: swtc_pkg::POINTS_RST,
        sav_delay: swtc_pkg::SAV_DELAY_FACT,
        sav_mode: swtc_pkg::SAV_MODE_FACT,
        sav_on: swtc_pkg::SAV_ON_FACT,
        default: '0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic out_level;

  assign out_level = (st_r.sw == SW_WAIT) || st_r.pulse;
  assign trig_out = out_level ^ st_r.out_neg;
  assign display_light_off = st_r.blank;
  assign display_text_off = st_r.blank && st_r.sav_mode;
  assign bit_error_measurement_on = st_r.ber_on;
  assign sweep_busy = (st_r.sw != SW_IDLE);
  assign pending_op = st_r.pending;
  assign point_index = st_r.pt;
  assign reg_rdata = st_r.rdata;

endmodule

// ### verif/swtc_chk_assertions.sv
// Port checker of the sweep trigger control block.
`timescale 1ns/1ps

module swtc_chk #(
  parameter int unsigned CYC_MS = 4,
  parameter int unsigned MS_HOUR = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [15:0] reg_rdata,
  input wire logic trig_out,
  input wire logic panel_activity,
  input wire logic display_light_off,
  input wire logic display_text_off,
  input wire logic bit_error_measurement_on,
  input wire logic sweep_busy,
  input wire logic pending_op
);
  // ------------------------------------------------------------
  // Command decode and control shadow
  // ------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic cmd, abrt, init, swp;
  assign cmd = reg_wr && reg_addr == swtc_pkg::OFF_CMD;
  assign abrt = cmd && (reg_wdata[0] || reg_wdata[4]);
  assign init = cmd && reg_wdata[1] && !abrt && !sweep_busy;
  assign swp = ctrl_r[5] || ctrl_r[6];
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ctrl_r <= 8'h08;
    else if (cmd && reg_wdata[4])
      ctrl_r <= 8'h08;
    else if (reg_wr && reg_addr == swtc_pkg::OFF_CTRL)
      ctrl_r <= reg_wdata[7:0];
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  abort_ber_a: assert property (
    cmd && reg_wdata[0] |=> !bit_error_measurement_on)
    else $error("measurement kept");
  abort_hold_a: assert property (
    abrt |=> $stable(pending_op)) else $error("pending moved early");
  abort_idle_a: assert property (
    abrt && (!ctrl_r[0] || reg_wdata[4]) |-> ##2 !sweep_busy && !pending_op)
    else $error("abort did not idle");
  abort_rearm_a: assert property (
    cmd && reg_wdata[0] && !reg_wdata[4] && ctrl_r[0] && swp && sweep_busy
    |-> ##2 sweep_busy && pending_op) else $error("no restart");
  init_start_a: assert property (
    init && swp |=> sweep_busy && pending_op) else $error("no start");
  init_refuse_a: assert property (
    init && !swp |=> !sweep_busy) else $error("bad start");
  sine_pulse_a: assert property (
    init && swp && ctrl_r[7] |=> trig_out != ctrl_r[2])
    else $error("no sweep pulse");
  idle_out_a: assert property (
    !sweep_busy && !$past(sweep_busy) |-> trig_out == ctrl_r[2])
    else $error("trigger out while idle");
  text_light_a: assert property (
    display_text_off |-> display_light_off) else $error("text without light");
  wake_up_a: assert property (
    panel_activity |-> ##[1:2] !display_light_off) else $error("still blank");

  cover property (init && swp);
  cover property (abrt && ctrl_r[0]);
  cover property (display_text_off);
  cover property (abrt && !ctrl_r[0] && sweep_busy);
endmodule

// ### verif/swtc_far.sv
// Far-side model: sweep hardware settling and trigger equipment.
`timescale 1ns/1ps

module swtc_far (
  input wire logic clk,
  input wire logic rst,
  input wire logic sweep_busy,
  input wire logic [3:0] settle_dly,
  input wire logic fire,
  input wire logic edge_neg,
  output logic point_settled,
  output logic trig_in
);
  logic [3:0] cnt_r;
  logic [2:0] hi_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      hi_r <= 3'h0;
    end else begin
      cnt_r <= (!sweep_busy || point_settled) ? 4'h0 : cnt_r + 4'h1;
      hi_r <= fire ? 3'h7 : (hi_r == 3'h0 ? 3'h0 : hi_r - 3'h1);
    end
  end
  assign point_settled = sweep_busy && cnt_r >= settle_dly;
  assign trig_in = (hi_r != 3'h0) ^ edge_neg;
endmodule

// ### verif/tb_top.sv
// Self-checking testbench of the sweep trigger control block.
`timescale 1ns/1ps

module tb_top;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic trig_key = 1'b0, panel_activity = 1'b0, fire = 1'b0;
  logic bit_error_measurement_start = 1'b0, edge_neg = 1'b0;
  logic [3:0] reg_addr = 4'h0, settle_dly = 4'h2;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [8:0] point_index, p;
  logic trig_in, point_settled, trig_out, display_light_off;
  logic display_text_off, bit_error_measurement_on, sweep_busy, pending_op;
  int n_fail = 0, tests_run = 0, seed = 7046, s, r;

  always #12.5 clk = ~clk;

  swtc_top #(.CYC_MS(4), .MS_HOUR(10)) dut_u (.clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig_in, .trig_key,
    .panel_activity, .point_settled, .trig_out, .display_light_off,
    .display_text_off, .bit_error_measurement_on,
    .bit_error_measurement_start, .sweep_busy, .pending_op, .point_index);
  swtc_far far_u (.clk, .rst, .sweep_busy, .settle_dly, .fire, .edge_neg,
    .point_settled, .trig_in);

  // ------------------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic tr(input logic [3:0] a, input logic [15:0] d, input bit ok);
    logic [15:0] o;
    rd(a, o);
    wr(a, d);
    rc(a, ok ? d : o);
  endtask
  task automatic cmd(input int b);
    wr(swtc_pkg::OFF_CMD, 16'h0001 << b);
  endtask
  task automatic kick(input int k);
    fire <= (k == 2);
    trig_key <= (k == 3);
    if (k < 2) cmd(k == 0 ? swtc_pkg::CMD_BUS_TRIG : swtc_pkg::CMD_FORCE);
    else cyc(1);
    fire <= 1'b0;
    trig_key <= 1'b0;
  endtask
  task automatic wt(input bit w, input logic v);
    int n;
    for (n = 0; n < 300 && (w ? sweep_busy : trig_out) !== v; n++) cyc(1);
    chk(16'(w ? sweep_busy : trig_out), 16'(v));
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    r = $random(seed);
    rc(swtc_pkg::OFF_CTRL, 16'h0008);
    rc(swtc_pkg::OFF_SAVER, 16'h0001);
    rc(4'h9, 16'h0000);
    tr(swtc_pkg::OFF_DWELL, 16'h0000, 0);
    tr(swtc_pkg::OFF_DWELL, 16'hea61, 0);
    tr(swtc_pkg::OFF_DWELL, 16'h0001 + r[14:0], 1);
    tr(swtc_pkg::OFF_POINTS, 16'h0001, 0);
    tr(swtc_pkg::OFF_POINTS, 16'h0192, 0);
    tr(swtc_pkg::OFF_POINTS, 16'h0191, 1);
    tr(swtc_pkg::OFF_SAVER, 16'h000d, 0);
    tr(swtc_pkg::OFF_SAVER, 16'h0035, 1);
    wr(swtc_pkg::OFF_CTRL, 16'h00ff);
    cmd(swtc_pkg::CMD_PRESET);
    rc(swtc_pkg::OFF_CTRL, 16'h0008);
    rc(swtc_pkg::OFF_DWELL, 16'h0002);
    rc(swtc_pkg::OFF_POINTS, 16'h0002);
    rc(swtc_pkg::OFF_SAVER, 16'h0035);
    cmd(swtc_pkg::CMD_PERS_PRESET);
    rc(swtc_pkg::OFF_SAVER, 16'h0001);
    wr(swtc_pkg::OFF_SAVER, 16'h0031);
    cyc(34);
    chk(16'(display_light_off), 16'h0000);
    cyc(14);
    chk({14'h0, display_text_off, display_light_off}, 16'h0003);
    panel_activity <= 1'b1;
    cyc(1);
    panel_activity <= 1'b0;
    cyc(2);
    chk(16'(display_light_off), 16'h0000);
    wr(swtc_pkg::OFF_SAVER, 16'h0001);
    cmd(swtc_pkg::CMD_INIT);
    cmd(swtc_pkg::CMD_FORCE);
    cyc(2);
    chk(16'(sweep_busy), 16'h0000);
    for (s = 0; s < 4; s++) begin
      if (s == 1) continue;
      r = $random(seed);
      edge_neg <= r[0];
      settle_dly <= {1'b0, r[3:1]};
      wr(swtc_pkg::OFF_CTRL, {8'h00, s == 0, 2'b01, 2'(s), 1'b0, r[0], 1'b0});
      cmd(swtc_pkg::CMD_INIT);
      cyc(3);
      wt(0, 1'b1);
      p = point_index;
      kick(1);
      for (r = 0; r < 12 && point_index === p; r++) cyc(1);
      chk(16'(point_index), 16'(p) + 16'h0001);
      wt(0, 1'b1);
      kick(s == 3 ? 0 : 3);
      cyc(6);
      chk(16'(point_index), 16'(p) + 16'h0001);
      kick(s);
      wt(1, 1'b0);
      chk(16'(pending_op), 16'h0000);
      cyc(20);
      chk(16'(sweep_busy), 16'h0000);
    end
    wr(swtc_pkg::OFF_DWELL, 16'h0001);
    wr(swtc_pkg::OFF_CTRL, 16'h004d);
    cmd(swtc_pkg::CMD_INIT);
    cyc(100);
    chk(16'(sweep_busy), 16'h0001);
    bit_error_measurement_start <= 1'b1;
    cyc(1);
    bit_error_measurement_start <= 1'b0;
    cyc(1);
    chk(16'(bit_error_measurement_on), 16'h0001);
    cmd(swtc_pkg::CMD_ABORT);
    cyc(1);
    chk(16'(bit_error_measurement_on), 16'h0000);
    cyc(2);
    chk(16'(sweep_busy), 16'h0001);
    wr(swtc_pkg::OFF_CTRL, 16'h004c);
    cyc(1);
    chk(16'(sweep_busy), 16'h0001);
    wt(1, 1'b0);
    chk(16'(trig_out), 16'h0001);
    cmd(swtc_pkg::CMD_INIT);
    cyc(2);
    chk(16'(sweep_busy), 16'h0001);
    cmd(swtc_pkg::CMD_ABORT);
    cyc(2);
    chk({14'h0, sweep_busy, pending_op}, 16'h0000);
    rc(swtc_pkg::OFF_STATUS, 16'h0000);
    rc(swtc_pkg::OFF_POINT_NOW, 16'h0000);
    wrap_up();
  end

  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
endmodule

bind swtc_top swtc_chk #(.CYC_MS(CYC_MS), .MS_HOUR(MS_HOUR)) chk_u (.clk,
  .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .trig_out,
  .panel_activity, .display_light_off, .display_text_off,
  .bit_error_measurement_on, .sweep_busy, .pending_op);
